// ===== rtl/sflc_pkg.sv
package sflc_pkg;

    // swing triangle phase
    typedef enum logic [1:0] {
        SW_IDLE,
        SW_RISE,
        SW_FALL
    } sflc_swing_e;

    // whole state of the block
    typedef struct packed {
        logic [1:0] len_sync;
        logic [1:0] cnt_sync;
        logic [1:0] rst_sync;
        logic len_prev;
        logic cnt_prev;
        logic [2:0] ctrl;
        logic [15:0] amp;
        logic [15:0] jump;
        logic [15:0] period;
        logic [15:0] ratio;
        logic [15:0] target_len;
        logic [15:0] ppm;
        logic [15:0] final_t;
        logic [15:0] inter_t;
        logic [15:0] centre;
        logic [15:0] max_f;
        logic [15:0] upper;
        logic [15:0] lower;
        logic [15:0] meas_len;
        logic [31:0] len_pulses;
        logic [15:0] event_count;
        sflc_swing_e swing;
        logic [15:0] phase;
        logic [31:0] tick;
        logic [15:0] freq_out;
        logic len_reached;
        logic fin_reached;
        logic int_reached;
        logic [2:0] irq_status;
        logic [2:0] irq_mask;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sflc_state_s;

endpackage : sflc_pkg

// ===== rtl/sflc_regs.svh
`ifndef SFLC_REGS_SVH
`define SFLC_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SFLC_CTRL_OFS 8'h00
`define SFLC_SWING_AMP_OFS 8'h04
`define SFLC_JUMP_AMP_OFS 8'h08
`define SFLC_SWING_PERIOD_OFS 8'h0c
`define SFLC_RISE_RATIO_OFS 8'h10
`define SFLC_TARGET_LEN_OFS 8'h14
`define SFLC_MEAS_LEN_OFS 8'h18
`define SFLC_PPM_OFS 8'h1c
`define SFLC_FINAL_CNT_OFS 8'h20
`define SFLC_INTER_CNT_OFS 8'h24
`define SFLC_CENTRE_OFS 8'h28
`define SFLC_MAX_FREQ_OFS 8'h2c
`define SFLC_UPPER_OFS 8'h30
`define SFLC_LOWER_OFS 8'h34
`define SFLC_EVENT_CNT_OFS 8'h38
`define SFLC_FREQ_OUT_OFS 8'h3c
`define SFLC_IRQ_STATUS_OFS 8'h40
`define SFLC_IRQ_MASK_OFS 8'h44
`define SFLC_LEN_PULSES_OFS 8'h48

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SFLC_CTRL_SWING_EN 0
`define SFLC_CTRL_BASE_SEL 1
`define SFLC_CTRL_CNT_CLEAR 2
`define SFLC_EV_LEN 0
`define SFLC_EV_INTER 1
`define SFLC_EV_FINAL 2

// ----------------------------------------------------------------
// reset values and limits (percent in 0.1 %, period in 0.1 s)
// ----------------------------------------------------------------
`define SFLC_SWING_AMP_RST 16'h0064
`define SFLC_JUMP_AMP_RST 16'h0064
`define SFLC_SWING_PERIOD_RST 16'h0064
`define SFLC_RISE_RATIO_RST 16'h01f4
`define SFLC_TARGET_LEN_RST 16'h03e8
`define SFLC_PPM_RST 16'h03e8
`define SFLC_FINAL_CNT_RST 16'h03e8
`define SFLC_INTER_CNT_RST 16'h03e8
`define SFLC_UPPER_RST 16'hffff
`define SFLC_PCT_FULL 16'h03e8
`define SFLC_JUMP_MAX 16'h01f4
`define SFLC_PERIOD_MAX 16'h7530

// ----------------------------------------------------------------
// timing: swing time base
// ----------------------------------------------------------------
`define SFLC_CLK_HZ 10000000
`define SFLC_TICK_TIME_MS 100

`endif

// ===== rtl/sflc_top.sv
// Operation
// RULE_01: with swing active, output frequency moves up and down around the centre.
// RULE_02: zero swing amplitude gives zero span and an unmodulated output.
// RULE_03: span is amplitude times centre (select 0) or maximum frequency (select 1).
// RULE_04: jump step is span times jump percentage, jump percentage capped at fifty.
// RULE_05: swung frequency is clamped between lower and upper frequency limits.
// RULE_06: one full swing lasts the programmed period, 0.1 s to 3000 s.
// RULE_07: rising time is period times rise ratio, ratio 0.1 to 100 percent.
// RULE_08: falling time is period times one minus the rise ratio.
// RULE_09: measured length is length pulses divided by pulses per meter.
// RULE_10: length reached output rises when measured length exceeds target length.
// RULE_11: length reset input clears the measured length.
// RULE_12: user routes length pulses to the length input, fast input for high rates.
// RULE_13: user routes count pulses to the count input, fast input for high rates.
// RULE_14: at final count target the final flag rises and counting stops.
// RULE_15: at intermediate target its flag rises and counting continues to final.
// RULE_16: software keeps intermediate target at or below final target.
// RULE_17: jump step applied downward at the top and upward at the bottom.
// RULE_18: each synchronised rising pulse edge counts once; accumulators saturate.
`include "sflc_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module sflc_top #(
    parameter int TICK_CYCLES = `SFLC_TICK_TIME_MS * (`SFLC_CLK_HZ / 1000)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic length_pulse_in,
    input wire logic count_pulse_in,
    input wire logic length_reset_in,
    output logic [15:0] freq_out,
    output logic length_reached,
    output logic final_count_reached,
    output logic intermediate_count_reached,
    output logic irq
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // value times a percentage given in 0.1 % steps
    function automatic logic [15:0] sflc_scale(input logic [15:0] val, input logic [15:0] pct);
        logic [31:0] prod;
        prod = val * pct;
        return 16'(prod / 32'(`SFLC_PCT_FULL));
    endfunction : sflc_scale

    // limit a value to a range
    function automatic logic [15:0] sflc_limit(input logic [15:0] val, input logic [15:0] lo,
                                               input logic [15:0] hi);
        if (val < lo) begin
            return lo;
        end
        if (val > hi) begin
            return hi;
        end
        return val;
    endfunction : sflc_limit

    // ramp value at step p; the last step of len reaches full
    function automatic longint sflc_ramp(input longint full, input logic [15:0] p,
        input logic [15:0] len);
        if (len <= 16'h0001) begin
            return full;
        end
        return full * longint'(p) / longint'(len - 16'h0001);
    endfunction : sflc_ramp

    // ----------------------------------------------------------------
    // state and working signals
    // ----------------------------------------------------------------
    sflc_pkg::sflc_state_s r;
    sflc_pkg::sflc_state_s next_r;
    logic len_edge;
    logic cnt_edge;

    logic swing_on;
    logic [15:0] amp_c;
    logic [15:0] jump_c;
    logic [15:0] period_c;
    logic [15:0] ratio_c;

    logic [15:0] span;
    logic [15:0] jmp;
    logic [15:0] rise_t;
    logic [15:0] fall_t;
    logic [15:0] cur_t;

    longint off;
    longint delta;
    longint freq;

    logic [31:0] len_q;
    logic [15:0] ppm_c;

    logic [2:0] ev;

    logic access;
    logic mapped;
    logic [31:0] rd;

    // reset values of the whole state
    localparam sflc_pkg::sflc_state_s RST = '{
        amp: `SFLC_SWING_AMP_RST, jump: `SFLC_JUMP_AMP_RST, period: `SFLC_SWING_PERIOD_RST,
        ratio: `SFLC_RISE_RATIO_RST, target_len: `SFLC_TARGET_LEN_RST, ppm: `SFLC_PPM_RST,
        final_t: `SFLC_FINAL_CNT_RST, inter_t: `SFLC_INTER_CNT_RST, upper: `SFLC_UPPER_RST,
        swing: sflc_pkg::SW_IDLE, default: '0
    };

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------

    // one process computes all next values
    always_comb begin
        next_r = r;
        // two-stage synchronisers on the pins
        next_r.len_sync = {r.len_sync[0], length_pulse_in};
        next_r.cnt_sync = {r.cnt_sync[0], count_pulse_in};
        next_r.rst_sync = {r.rst_sync[0], length_reset_in};
        next_r.len_prev = r.len_sync[1];
        next_r.cnt_prev = r.cnt_sync[1];
        len_edge = r.len_sync[1] & ~r.len_prev; // [RULE_18]
        cnt_edge = r.cnt_sync[1] & ~r.cnt_prev; // [RULE_18]

        // swing span and jump step
        amp_c = sflc_limit(r.amp, 16'h0000, `SFLC_PCT_FULL);
        jump_c = sflc_limit(r.jump, 16'h0000, `SFLC_JUMP_MAX); // [RULE_04]
        period_c = sflc_limit(r.period, 16'h0001, `SFLC_PERIOD_MAX); // [RULE_06]
        ratio_c = sflc_limit(r.ratio, 16'h0001, `SFLC_PCT_FULL); // [RULE_07]

        span = sflc_scale(r.ctrl[`SFLC_CTRL_BASE_SEL] ? r.max_f : r.centre, amp_c); // [RULE_03]
        jmp = sflc_scale(span, jump_c); // [RULE_04]
        rise_t = sflc_limit(sflc_scale(period_c, ratio_c), 16'h0001, period_c); // [RULE_07]
        fall_t = period_c - rise_t; // [RULE_08]

        swing_on = r.ctrl[`SFLC_CTRL_SWING_EN] && (amp_c != 16'h0000); // [RULE_02]
        cur_t = (r.swing == sflc_pkg::SW_FALL) ? fall_t : rise_t;

        // triangle sequencer on the 0.1 s time base
        if (!swing_on) begin
            next_r.swing = sflc_pkg::SW_IDLE; // [RULE_02]
            next_r.phase = '0;
            next_r.tick = '0;
        end else begin
            case (r.swing)
                sflc_pkg::SW_IDLE: begin
                    next_r.swing = sflc_pkg::SW_RISE; // [RULE_01]
                    next_r.phase = '0;
                    next_r.tick = '0;
                end
                sflc_pkg::SW_RISE, sflc_pkg::SW_FALL: begin
                    if (r.tick >= 32'(TICK_CYCLES - 1)) begin
                        next_r.tick = '0;
                        if (32'(r.phase) + 32'd1 >= 32'(cur_t)) begin
                            next_r.phase = '0;
                            // turning point; a zero falling time stays rising
                            if (r.swing == sflc_pkg::SW_RISE && fall_t != 16'h0000) begin
                                next_r.swing = sflc_pkg::SW_FALL; // [RULE_08]
                            end else begin
                                next_r.swing = sflc_pkg::SW_RISE; // [RULE_06]
                            end
                        end else begin
                            next_r.phase = r.phase + 16'h0001;
                        end
                    end else begin
                        next_r.tick = r.tick + 32'd1;
                    end
                end
                default: begin
                    next_r.swing = sflc_pkg::SW_IDLE;
                end
            endcase
        end

        // offset: ramps span from jump-shifted start, step of jump at each turn
        delta = 2 * longint'(span) - longint'(jmp);

        case (r.swing)
            sflc_pkg::SW_RISE: begin
                off = longint'(jmp) - longint'(span)
                      + sflc_ramp(delta, r.phase, rise_t); // [RULE_17]
            end
            sflc_pkg::SW_FALL: begin
                off = longint'(span) - longint'(jmp)
                      - sflc_ramp(delta, r.phase, fall_t); // [RULE_17]
            end
            default: begin
                off = 0;
            end
        endcase
        freq = longint'(r.centre) + off; // [RULE_01]

        if (freq > longint'(r.upper)) begin
            freq = longint'(r.upper); // [RULE_05]
        end

        if (freq < longint'(r.lower)) begin
            freq = longint'(r.lower); // [RULE_05]
        end

        if (freq < 0) begin
            freq = 0;
        end
        next_r.freq_out = 16'(freq);

        // length accumulation, pulses per meter held in 0.1 steps
        ppm_c = (r.ppm == 16'h0000) ? 16'h0001 : r.ppm;

        if (r.rst_sync[1]) begin
            next_r.len_pulses = '0; // [RULE_11]
        end else if (len_edge && r.len_pulses != 32'hffffffff) begin
            next_r.len_pulses = r.len_pulses + 32'd1; // [RULE_18]
        end

        len_q = 32'((64'(r.len_pulses) * 64'd10) / 64'(ppm_c)); // [RULE_09]
        next_r.meas_len = (len_q > 32'h0000ffff) ? 16'hffff : len_q[15:0]; // [RULE_18]
        if (r.rst_sync[1]) begin
            next_r.meas_len = '0; // [RULE_11]
        end

        next_r.len_reached = r.meas_len > r.target_len; // [RULE_10]

        // event counter, stops once the final target is reached
        if (r.ctrl[`SFLC_CTRL_CNT_CLEAR]) begin
            next_r.event_count = '0;
        end else if (cnt_edge && !r.fin_reached && r.event_count != 16'hffff) begin
            next_r.event_count = r.event_count + 16'h0001; // [RULE_14] [RULE_18]
        end

        next_r.ctrl[`SFLC_CTRL_CNT_CLEAR] = 1'b0;

        next_r.fin_reached = r.event_count >= r.final_t; // [RULE_14]
        next_r.int_reached = r.event_count >= r.inter_t; // [RULE_15]

        // rising edges of the reached flags are the interrupt events
        ev = '0;
        ev[`SFLC_EV_LEN] = next_r.len_reached & ~r.len_reached;
        ev[`SFLC_EV_INTER] = next_r.int_reached & ~r.int_reached;
        ev[`SFLC_EV_FINAL] = next_r.fin_reached & ~r.fin_reached;

        // apb read decode, registered at the setup edge and answered in the access cycle
        mapped = 1'b1;
        rd = '0;
        case (paddr)
            `SFLC_CTRL_OFS: rd = 32'(r.ctrl);
            `SFLC_SWING_AMP_OFS: rd = 32'(r.amp);
            `SFLC_JUMP_AMP_OFS: rd = 32'(r.jump);
            `SFLC_SWING_PERIOD_OFS: rd = 32'(r.period);
            `SFLC_RISE_RATIO_OFS: rd = 32'(r.ratio);
            `SFLC_TARGET_LEN_OFS: rd = 32'(r.target_len);
            `SFLC_MEAS_LEN_OFS: rd = 32'(r.meas_len);
            `SFLC_PPM_OFS: rd = 32'(r.ppm);
            `SFLC_FINAL_CNT_OFS: rd = 32'(r.final_t);
            `SFLC_INTER_CNT_OFS: rd = 32'(r.inter_t);
            `SFLC_CENTRE_OFS: rd = 32'(r.centre);
            `SFLC_MAX_FREQ_OFS: rd = 32'(r.max_f);
            `SFLC_UPPER_OFS: rd = 32'(r.upper);
            `SFLC_LOWER_OFS: rd = 32'(r.lower);
            `SFLC_EVENT_CNT_OFS: rd = 32'(r.event_count);
            `SFLC_FREQ_OUT_OFS: rd = 32'(r.freq_out);
            `SFLC_IRQ_STATUS_OFS: rd = 32'(r.irq_status);
            `SFLC_IRQ_MASK_OFS: rd = 32'(r.irq_mask);
            `SFLC_LEN_PULSES_OFS: rd = r.len_pulses;
            default: mapped = 1'b0;
        endcase

        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        if (psel && !penable) begin
            next_r.pready = 1'b1;
            next_r.pslverr = ~mapped;
            next_r.prdata = pwrite ? 32'h00000000 : rd;
        end

        // apb write at the completing edge; read-only offsets ignore writes
        access = psel && penable && r.pready;
        if (access && pwrite && !r.pslverr) begin
            case (paddr)
                `SFLC_CTRL_OFS: next_r.ctrl = pwdata[2:0];
                `SFLC_SWING_AMP_OFS: next_r.amp = pwdata[15:0];
                `SFLC_JUMP_AMP_OFS: next_r.jump = pwdata[15:0];
                `SFLC_SWING_PERIOD_OFS: next_r.period = pwdata[15:0];
                `SFLC_RISE_RATIO_OFS: next_r.ratio = pwdata[15:0];
                `SFLC_TARGET_LEN_OFS: next_r.target_len = pwdata[15:0];
                `SFLC_PPM_OFS: next_r.ppm = pwdata[15:0];
                `SFLC_FINAL_CNT_OFS: next_r.final_t = pwdata[15:0];
                `SFLC_INTER_CNT_OFS: next_r.inter_t = pwdata[15:0];
                `SFLC_CENTRE_OFS: next_r.centre = pwdata[15:0];
                `SFLC_MAX_FREQ_OFS: next_r.max_f = pwdata[15:0];
                `SFLC_UPPER_OFS: next_r.upper = pwdata[15:0];
                `SFLC_LOWER_OFS: next_r.lower = pwdata[15:0];
                `SFLC_IRQ_MASK_OFS: next_r.irq_mask = pwdata[2:0];
                default: next_r.ctrl = next_r.ctrl;
            endcase
        end

        // status clears only the bits that the read returned; new events win
        if (access && !pwrite && paddr == `SFLC_IRQ_STATUS_OFS) begin
            next_r.irq_status = r.irq_status & ~r.prdata[2:0];
        end
        next_r.irq_status = next_r.irq_status | ev;

        next_r.irq = |(next_r.irq_status & next_r.irq_mask);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------

    // single register for the whole state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= RST;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from the state register
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign freq_out = r.freq_out;
    assign length_reached = r.len_reached;
    assign final_count_reached = r.fin_reached;
    assign intermediate_count_reached = r.int_reached;
    assign irq = r.irq;

endmodule : sflc_top

`default_nettype wire

// ===== verification/sflc_pulse_src.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// pulse sources on the digital inputs
// ----------------------------------------
module sflc_pulse_src (
    input wire logic pclk,
    output logic len_pulse,
    output logic cnt_pulse,
    output logic len_clr
);
    // inputs idle low from time zero
    initial begin
        len_pulse = 1'b0;
        cnt_pulse = 1'b0;
        len_clr = 1'b0;
    end
    // n pulses, each level held w cycles; w of 2 or more stays at or under pclk/4
    task automatic burst(input int n, input int w, input logic cnt);
        for (int i = 0; i < n; i++) begin
            repeat (w) @(posedge pclk);
            if (cnt) cnt_pulse <= 1'b1;
            else len_pulse <= 1'b1;
            repeat (w) @(posedge pclk);
            cnt_pulse <= 1'b0;
            len_pulse <= 1'b0;
        end
    endtask : burst
    // length reset level, changed just after an edge
    task automatic set_clr(input logic v);
        @(posedge pclk);
        len_clr <= v;
    endtask : set_clr
endmodule : sflc_pulse_src
`default_nettype wire

// ===== verification/sflc_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// port checks for the swing and counter block
// ----------------------------------------
module sflc_top_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic count_pulse_in,
    input wire logic length_reset_in,
    input wire logic length_reached,
    input wire logic final_count_reached,
    input wire logic intermediate_count_reached
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // held length reset keeps the length flag low
    property p_len_clr; length_reset_in [*5] |=> !length_reached; endproperty
    a_len_clr: assert property (p_len_clr) else $error("length flag under reset");
    // final flag holds once reached while no bus write lands
    property p_fin_hold;
        final_count_reached && !psel && !$past(psel) && !$past(psel, 2) |=> final_count_reached;
    endproperty
    a_fin_hold: assert property (p_fin_hold) else $error("final flag dropped");
    // intermediate flag holds while counting on
    property p_int_hold;
        intermediate_count_reached && !psel && !$past(psel) && !$past(psel, 2)
            |=> intermediate_count_reached;
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("inter flag dropped");
    // with inter target not above final, final implies inter
    property p_fin_int; final_count_reached |-> intermediate_count_reached; endproperty
    a_fin_int: assert property (p_fin_int) else $error("final without inter");
    // a counted rise needs a pulse on the count pin a few cycles back
    property p_cnt_cause;
        $rose(intermediate_count_reached) && !$past(psel) && !$past(psel, 2)
            |-> $past(count_pulse_in, 3);
    endproperty
    a_cnt_cause: assert property (p_cnt_cause) else $error("flag without pulse");
    // bus answer timing
    property p_rdy_pulse; pready |=> !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
    property p_zero_wait; psel && !penable |=> pready; endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("no answer in access cycle");
    property p_err_rdy; pslverr |-> pready && psel && penable; endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("error outside answer");
    c_fin: cover property ($rose(final_count_reached));
    c_len: cover property ($rose(length_reached));
    c_err: cover property (pslverr);
endmodule : sflc_top_chk

bind sflc_top sflc_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .count_pulse_in(count_pulse_in),
    .length_reset_in(length_reset_in), .length_reached(length_reached),
    .final_count_reached(final_count_reached),
    .intermediate_count_reached(intermediate_count_reached));
`default_nettype wire

// ===== verification/tb_swing_freq_length_counter.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// self-checking bench
// ----------------------------------------
module tb_swing_freq_length_counter;
    typedef struct {logic [31:0] d; logic e; logic r;} sflc_note_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, lp, cp, lr, len_hit, fin_hit, int_hit, irq;
    logic [15:0] freq_out, mx, mn, prev, jmp, c;
    logic [7:0] ra [11] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20, 8'h24, 8'h30,
                           8'h34, 8'h44};
    logic [15:0] rv [11] = '{16'h64, 16'h64, 16'h64, 16'h1f4, 16'h3e8, 16'h3e8, 16'h3e8,
                            16'h3e8, 16'hffff, 16'h0, 16'h0};
    sflc_note_s q[$];
    sflc_note_s nt;
    int n_mismatch = 0;
    int samples_checked = 0;
    int seed = 14;
    int t_top, per, fall;

    sflc_top #(.TICK_CYCLES(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .length_pulse_in(lp), .count_pulse_in(cp),
        .length_reset_in(lr), .freq_out(freq_out), .length_reached(len_hit),
        .final_count_reached(fin_hit), .intermediate_count_reached(int_hit), .irq(irq));
    sflc_pulse_src u_src (.pclk(pclk), .len_pulse(lp), .cnt_pulse(cp), .len_clr(lr));

    // 10 MHz clock
    always #50 pclk = ~pclk;

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("ERROR %s exp %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk

    // one bus transfer; the expected answer is noted first
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic err);
        int k;
        k = 0;
        q.push_back('{e, err, !w});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, e, 1'b0);
    endtask : rd

    // tracks extremes, top drops and the time from a top to the next rise
    task automatic watch(input int n);
        repeat (4) @(posedge pclk);
        mx = 16'h0;
        mn = 16'hffff;
        jmp = 16'h0;
        t_top = -1;
        per = 0;
        fall = 0;
        prev = freq_out;
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            if (freq_out > mx) mx = freq_out;
            if (freq_out < mn) mn = freq_out;
            if (freq_out > prev && t_top >= 0 && fall == 0) fall = i - t_top;
            if (prev > freq_out + 16'h46) begin
                jmp = prev - freq_out;
                if (t_top >= 0) per = i - t_top;
                t_top = i;
            end
            prev = freq_out;
        end
    endtask : watch

    // compares each finished transfer with the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && q.size() > 0) begin
            nt = q.pop_front();
            samples_checked++;
            if (pslverr !== nt.e || (nt.r && prdata !== nt.d)) begin
                $display("ERROR apb %h exp %h/%b seen %h/%b", paddr, nt.d, nt.e, prdata, pslverr);
                n_mismatch++;
            end
        end
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge pclk);
        n_mismatch++;
        report_and_stop();
    end

    // main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 11; i++) rd(ra[i], {16'h0, rv[i]});
        apb(1'b0, 8'h80, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h80, 32'h5, 32'h0, 1'b1);
        for (int i = 0; i < 3; i++) begin
            c = 16'($random(seed)) & 16'h0fff;
            wr(8'h28, {16'h0, c});
            repeat (4) @(posedge pclk);
            chk("freq_out", {16'h0, c}, {16'h0, freq_out});
        end
        wr(8'h28, 32'h3e8);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h1);
        watch(40);
        chk("flat", {16'h3e8, 16'h3e8}, {mx, mn});
        wr(8'h30, 32'h384);
        repeat (4) @(posedge pclk);
        chk("upper", 32'h384, {16'h0, freq_out});
        wr(8'h30, 32'hffff);
        wr(8'h34, 32'h44c);
        repeat (4) @(posedge pclk);
        chk("lower", 32'h44c, {16'h0, freq_out});
        wr(8'h34, 32'h0);
        wr(8'h04, 32'hc8);
        wr(8'h08, 32'h258);
        wr(8'h0c, 32'h0a);
        wr(8'h10, 32'h12c);
        watch(130);
        chk("top", 32'h4b0, {16'h0, mx});
        chk("bottom", 32'h320, {16'h0, mn});
        chk("jump", 32'h64, {16'h0, jmp});
        chk("period", 32'h28, 32'(per));
        chk("fall", 32'h1c, 32'(fall));
        chk("rise", 32'h0c, 32'(per - fall));
        wr(8'h2c, 32'hbb8);
        wr(8'h04, 32'h64);
        wr(8'h00, 32'h3);
        watch(90);
        chk("top_max", 32'h514, {16'h0, mx});
        wr(8'h30, 32'h4e2);
        watch(90);
        chk("top_cut", 32'h4e2, {16'h0, mx});
        wr(8'h30, 32'hffff);
        wr(8'h24, 32'h3);
        wr(8'h20, 32'h5);
        wr(8'h44, 32'h6);
        u_src.burst(3, 3, 1'b1);
        repeat (5) @(posedge pclk);
        chk("inter", 32'h1, {30'h0, fin_hit, int_hit});
        u_src.burst(4, 8, 1'b1);
        repeat (5) @(posedge pclk);
        chk("final", 32'h7, {29'h0, irq, fin_hit, int_hit});
        rd(8'h38, 32'h5);
        rd(8'h40, 32'h6);
        repeat (3) @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        wr(8'h44, 32'h0);
        wr(8'h00, 32'h4);
        repeat (3) @(posedge pclk);
        chk("clear", 32'h0, {30'h0, fin_hit, int_hit});
        u_src.burst(3, 3, 1'b1);
        repeat (5) @(posedge pclk);
        chk("masked", 32'h1, {30'h0, irq, int_hit});
        rd(8'h40, 32'h2);
        wr(8'h38, 32'h55);
        rd(8'h38, 32'h3);
        wr(8'h1c, 32'h14);
        wr(8'h14, 32'h2);
        u_src.burst(4, 3, 1'b0);
        repeat (5) @(posedge pclk);
        chk("len_eq", 32'h0, {31'h0, len_hit});
        rd(8'h18, 32'h2);
        u_src.burst(2, 3, 1'b0);
        repeat (5) @(posedge pclk);
        chk("len_over", 32'h1, {31'h0, len_hit});
        rd(8'h48, 32'h6);
        u_src.set_clr(1'b1);
        u_src.burst(2, 3, 1'b0);
        repeat (5) @(posedge pclk);
        chk("len_clr", 32'h0, {31'h0, len_hit});
        rd(8'h18, 32'h0);
        u_src.set_clr(1'b0);
        repeat (4) @(posedge pclk);
        report_and_stop();
    end
endmodule : tb_swing_freq_length_counter
`default_nettype wire
